/* File: pkg/rie_pkg.sv */
package rie_pkg;

	// ******************************
	// Widths and instruction fields
	// ******************************
	localparam int WORD_W = 24;
	localparam int IDX_W = 15;
	localparam int ADDR_W = 8;
	localparam int CNT_W = 6;
	localparam int OPC_HI = 23;
	localparam int OPC_LO = 18;
	localparam int DIR_BIT = 17;
	localparam int IDX_HI = 16;
	localparam int IDX_LO = 15;
	localparam int IMM_HI = 14;
	localparam int CHAR_HI = 16;
	localparam int SUM_SIGN = 23;
	localparam int SUM_CNT_HI = 5;

	// ******************************
	// Operation codes
	// ******************************
	localparam logic [5:0] OP_EQ_SKIP = 6'h04;
	localparam logic [5:0] OP_GE_SKIP = 6'h05;
	localparam logic [5:0] OP_IDX_SKIP = 6'h08;
	localparam logic [5:0] OP_CHAR_PTR = 6'h09;
	localparam logic [5:0] OP_SHIFT_ONE = 6'h0a;
	localparam logic [5:0] OP_SHIFT_DBL = 6'h0b;
	localparam logic [5:0] OP_ENTER = 6'h0c;
	localparam logic [5:0] OP_ADD = 6'h0d;
	localparam logic [5:0] OP_XOR = 6'h0e;
	localparam logic [5:0] OP_AND = 6'h0f;

	// ******************************
	// Shift and scale counts
	// ******************************
	localparam logic [5:0] ROT_SINGLE = 6'h18;
	localparam logic [5:0] ROT_DOUBLE = 6'h30;
	localparam logic [5:0] SCALE_MAX = 6'h30;
	localparam logic [14:0] IDX_MINUS_ONE = 15'h7ffe;
	localparam logic [14:0] IDX_PLUS_ONE = 15'h0001;

	// ******************************
	// Register offsets and status bits
	// ******************************
	localparam logic [7:0] OFS_MAIN = 8'h00;
	localparam logic [7:0] OFS_AUX = 8'h04;
	localparam logic [7:0] OFS_IDX1 = 8'h08;
	localparam logic [7:0] OFS_IDX2 = 8'h0c;
	localparam logic [7:0] OFS_IDX3 = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	localparam int ST_BUSY = 0;
	localparam int ST_SKIP = 1;
	localparam int ST_BAD = 2;
	localparam int ST_CNT_LO = 8;
	localparam logic [23:0] RST_WORD = 24'h000000;
	localparam logic [14:0] RST_IDX = 15'h0000;
	localparam logic [5:0] RST_CNT = 6'h00;

	typedef enum logic [0:0] {
		RIE_IDLE = 1'b0,
		RIE_SCALE = 1'b1
	} rie_state_t;

	typedef struct packed {
		rie_state_t st;
		logic [23:0] a;
		logic [23:0] q;
		logic [2:0][14:0] bx;
		logic [5:0] cnt;
		logic [14:0] sc_imm;
		logic [1:0] sc_idx;
		logic [14:0] sc_pc;
		logic busy;
		logic done;
		logic skip;
		logic bad_op;
		logic [14:0] next_pc;
		logic [23:0] rdata;
	} rie_state_bundle_t;

endpackage

/* File: src/rie_exec.sv */
`timescale 1ns/100ps
// How it works
// - Up skip: match clears index, goes P+2
// - Down skip: match clears, else decrement
// - Char pointer: load 17 bits into main, upper bits cleared, or sign-extended if designator set
// - Designator and index field pick register
// - Both zero in skips compares with zero
// - Both zero in enter/add/xor/and: no-op
// - Equal skip goes to P+2
// - Greater-or-equal skip goes to P+2
// - Enter overwrites register with immediate
// - Add immediate into register
// - Exclusive-or immediate into register
// - And immediate into register
// - Shift count from index plus immediate
// - Single left shift rotates modulo 24
// - Single right shift extends sign
// - Double left rotates 48-bit pair
// - Double right shift extends sign
// - Scale rotates until bits 46, 47 differ
// - Zero pair scales exactly 48 times
// - Residue immediate minus count to index
// - Index counting never gives negative zero
// - Next address is P+1 or P+2
module rie_exec (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic exec_start,
	input wire logic [rie_pkg::WORD_W-1:0] exec_instr,
	input wire logic [rie_pkg::IDX_W-1:0] exec_pc,
	output logic exec_done,
	output logic [rie_pkg::IDX_W-1:0] exec_next_pc,
	output logic exec_skip,
	output logic exec_busy,
	output logic exec_bad_op,
	input wire logic [rie_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [rie_pkg::WORD_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [rie_pkg::WORD_W-1:0] reg_rdata
);
	import rie_pkg::*;

	// ******************************
	// One's complement helpers
	// ******************************
	function automatic logic [23:0] oc_add24(input logic [23:0] x, input logic [23:0] y);
		logic [24:0] s;
		s = {1'b0, x} + {1'b0, y};
		return s[23:0] + {23'h0, s[24]};
	endfunction

	// Negative zero folded to plus zero so counts stop at zero
	function automatic logic [14:0] oc_add15(input logic [14:0] x, input logic [14:0] y);
		logic [15:0] s;
		logic [14:0] r;
		s = {1'b0, x} + {1'b0, y};
		r = s[14:0] + {14'h0, s[15]};
		return (r == 15'h7fff) ? 15'h0000 : r;
	endfunction

	function automatic logic [23:0] oc_norm(input logic [23:0] x);
		return (x == 24'hffffff) ? 24'h000000 : x;
	endfunction

	function automatic logic oc_ge(input logic [23:0] x, input logic [23:0] y);
		logic [23:0] xn;
		logic [23:0] yn;
		xn = oc_norm(x);
		yn = oc_norm(y);
		if (xn[23] != yn[23]) begin
			return !xn[23];
		end
		return xn >= yn;
	endfunction

	rie_state_bundle_t s_ff;
	rie_state_bundle_t nxt_s;

	// ******************************
	// Instruction decode
	// ******************************
	logic [5:0] opc;
	logic dsg;
	logic [1:0] ixf;
	logic [14:0] imm;
	logic [16:0] chr;
	logic go;
	logic [14:0] idx_val;
	logic sel_main;
	logic sel_aux;
	logic sel_ext;
	logic sel_idx;
	logic [23:0] reg_val;
	logic [23:0] opnd;
	logic is_eq;
	logic is_ge;
	logic [14:0] pc1;
	logic [14:0] pc2;

	assign opc = exec_instr[OPC_HI:OPC_LO];
	assign dsg = exec_instr[DIR_BIT];
	assign ixf = exec_instr[IDX_HI:IDX_LO];
	assign imm = exec_instr[IMM_HI:0];
	assign chr = exec_instr[CHAR_HI:0];
	assign go = exec_start && !s_ff.busy;
	assign idx_val = (ixf == 2'd0) ? RST_IDX : s_ff.bx[ixf - 2'd1];
	assign sel_main = dsg && !ixf[0];
	assign sel_aux = dsg && ixf[0];
	assign sel_ext = dsg && !ixf[1];
	assign sel_idx = !dsg && (ixf != 2'd0);
	assign reg_val = sel_main ? s_ff.a : (sel_aux ? s_ff.q : {9'h000, idx_val});
	assign opnd = sel_ext ? {{9{imm[14]}}, imm} : {9'h000, imm};
	assign is_eq = oc_norm(reg_val) == oc_norm(opnd);
	assign is_ge = oc_ge(reg_val, opnd);
	assign pc1 = 15'(exec_pc + 15'd1);
	assign pc2 = 15'(exec_pc + 15'd2);

	// ******************************
	// Shift datapath
	// ******************************
	logic [23:0] shift_sum;
	logic shift_right;
	logic [5:0] shift_n;
	logic [5:0] n24;
	logic [5:0] n48;
	logic [23:0] shift_src;
	logic [47:0] rot1_wide;
	logic [95:0] rot2_wide;
	logic [23:0] single_res;
	logic [47:0] double_res;

	// Only bits 5..0 and the sign of the sum steer the shifter
	assign shift_sum = oc_add24({{9{idx_val[14]}}, idx_val}, {{9{imm[14]}}, imm});
	assign shift_right = shift_sum[SUM_SIGN];
	assign shift_n = shift_right ? ~shift_sum[SUM_CNT_HI:0] : shift_sum[SUM_CNT_HI:0];
	assign n24 = 6'(shift_n % ROT_SINGLE);
	assign n48 = 6'(shift_n % ROT_DOUBLE);
	assign shift_src = dsg ? s_ff.q : s_ff.a;
	assign rot1_wide = {shift_src, shift_src} << n24;
	assign rot2_wide = {s_ff.a, s_ff.q, s_ff.a, s_ff.q} << n48;
	assign single_res = shift_right ? 24'($signed(shift_src) >>> shift_n)
		: rot1_wide[47:24];
	assign double_res = shift_right ? 48'($signed({s_ff.a, s_ff.q}) >>> shift_n)
		: rot2_wide[95:48];

	// ******************************
	// Scale step
	// ******************************
	logic scale_stop;
	logic [14:0] residue;

	assign scale_stop = (s_ff.a[23] != s_ff.a[22]) || (s_ff.cnt == SCALE_MAX);
	assign residue = oc_add15(s_ff.sc_imm, ~{9'h000, s_ff.cnt});

	// ******************************
	// Next state
	// ******************************
	always_comb begin
		logic [23:0] res;
		res = RST_WORD;
		nxt_s = s_ff;
		nxt_s.done = 1'b0;
		nxt_s.rdata = RST_WORD;
		// Bus writes held off while scaling, so the pair stays coherent
		if (reg_wr && !s_ff.busy) begin
			if (reg_addr == OFS_MAIN) begin
				nxt_s.a = reg_wdata;
			end else if (reg_addr == OFS_AUX) begin
				nxt_s.q = reg_wdata;
			end else if (reg_addr == OFS_IDX1) begin
				nxt_s.bx[0] = reg_wdata[14:0];
			end else if (reg_addr == OFS_IDX2) begin
				nxt_s.bx[1] = reg_wdata[14:0];
			end else if (reg_addr == OFS_IDX3) begin
				nxt_s.bx[2] = reg_wdata[14:0];
			end
		end
		if (reg_rd) begin
			if (reg_addr == OFS_MAIN) begin
				nxt_s.rdata = s_ff.a;
			end else if (reg_addr == OFS_AUX) begin
				nxt_s.rdata = s_ff.q;
			end else if (reg_addr == OFS_IDX1) begin
				nxt_s.rdata = {9'h000, s_ff.bx[0]};
			end else if (reg_addr == OFS_IDX2) begin
				nxt_s.rdata = {9'h000, s_ff.bx[1]};
			end else if (reg_addr == OFS_IDX3) begin
				nxt_s.rdata = {9'h000, s_ff.bx[2]};
			end else if (reg_addr == OFS_STATUS) begin
				nxt_s.rdata[ST_BUSY] = s_ff.busy;
				nxt_s.rdata[ST_SKIP] = s_ff.skip;
				nxt_s.rdata[ST_BAD] = s_ff.bad_op;
				nxt_s.rdata[ST_CNT_LO +: 6] = s_ff.cnt;
			end
		end
		case (s_ff.st)
			RIE_IDLE: begin
				if (go) begin
					nxt_s.done = 1'b1;
					nxt_s.skip = 1'b0;
					nxt_s.bad_op = 1'b0;
					nxt_s.next_pc = pc1;
					case (opc)
						OP_EQ_SKIP: begin
							nxt_s.skip = is_eq;
							nxt_s.next_pc = is_eq ? pc2 : pc1;
						end
						OP_GE_SKIP: begin
							nxt_s.skip = is_ge;
							nxt_s.next_pc = is_ge ? pc2 : pc1;
						end
						OP_ENTER, OP_ADD, OP_XOR, OP_AND: begin
							res = opnd;
							if (opc == OP_ADD) begin
								res = sel_idx ? {9'h000, oc_add15(idx_val, imm)}
									: oc_add24(reg_val, opnd);
							end else if (opc == OP_XOR) begin
								res = reg_val ^ opnd;
							end else if (opc == OP_AND) begin
								res = reg_val & opnd;
							end
							// Designator and field both zero fall through untouched
							if (sel_main) begin
								nxt_s.a = res;
							end else if (sel_aux) begin
								nxt_s.q = res;
							end else if (sel_idx) begin
								nxt_s.bx[ixf - 2'd1] = res[14:0];
							end
						end
						OP_IDX_SKIP: begin
							nxt_s.skip = idx_val == imm;
							nxt_s.next_pc = (idx_val == imm) ? pc2 : pc1;
							if (ixf != 2'd0) begin
								if (idx_val == imm) begin
									nxt_s.bx[ixf - 2'd1] = RST_IDX;
								end else begin
									nxt_s.bx[ixf - 2'd1] = oc_add15(idx_val,
										dsg ? IDX_MINUS_ONE : IDX_PLUS_ONE);
								end
							end
						end
						OP_CHAR_PTR: begin
							nxt_s.a = dsg ? {{7{chr[16]}}, chr} : {7'h00, chr};
						end
						OP_SHIFT_ONE: begin
							if (dsg) begin
								nxt_s.q = single_res;
							end else begin
								nxt_s.a = single_res;
							end
						end
						OP_SHIFT_DBL: begin
							if (dsg) begin
								// Scale runs one place per clock; done comes at the end
								nxt_s.done = 1'b0;
								nxt_s.st = RIE_SCALE;
								nxt_s.busy = 1'b1;
								nxt_s.cnt = RST_CNT;
								nxt_s.sc_imm = imm;
								nxt_s.sc_idx = ixf;
								nxt_s.sc_pc = pc1;
							end else begin
								nxt_s.a = double_res[47:24];
								nxt_s.q = double_res[23:0];
							end
						end
						default: begin
							nxt_s.bad_op = 1'b1;
						end
					endcase
				end
			end
			RIE_SCALE: begin
				if (scale_stop) begin
					nxt_s.st = RIE_IDLE;
					nxt_s.busy = 1'b0;
					nxt_s.done = 1'b1;
					nxt_s.next_pc = s_ff.sc_pc;
					if (s_ff.sc_idx != 2'd0) begin
						nxt_s.bx[s_ff.sc_idx - 2'd1] = residue;
					end
				end else begin
					{nxt_s.a, nxt_s.q} = {s_ff.a[22:0], s_ff.q, s_ff.a[23]};
					nxt_s.cnt = 6'(s_ff.cnt + 6'd1);
				end
			end
			default: begin
				nxt_s.st = RIE_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			s_ff <= '{st: RIE_IDLE, a: RST_WORD, q: RST_WORD, bx: {3{RST_IDX}}, cnt: RST_CNT,
				sc_imm: RST_IDX, sc_idx: 2'd0, sc_pc: RST_IDX, busy: 1'b0, done: 1'b0,
				skip: 1'b0, bad_op: 1'b0, next_pc: RST_IDX, rdata: RST_WORD};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign exec_done = s_ff.done;
	assign exec_next_pc = s_ff.next_pc;
	assign exec_skip = s_ff.skip;
	assign exec_busy = s_ff.busy;
	assign exec_bad_op = s_ff.bad_op;
	assign reg_rdata = s_ff.rdata;

	// ******************************
	// Checks
	// ******************************
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);

	property p_idx_up_hit;
		go && opc == OP_IDX_SKIP && !dsg && ixf != 2'd0 && idx_val == imm
			|=> exec_done && exec_next_pc == 15'($past(exec_pc) + 15'd2)
			&& s_ff.bx[$past(ixf) - 2'd1] == 15'h0000;
	endproperty
	a_idx_up_hit: assert property (p_idx_up_hit) else $error("up skip hit wrong");

	property p_idx_down_miss;
		go && opc == OP_IDX_SKIP && dsg && ixf != 2'd0 && idx_val != imm
			|=> exec_next_pc == 15'($past(exec_pc) + 15'd1) && !exec_skip
			&& s_ff.bx[$past(ixf) - 2'd1] == oc_add15($past(idx_val), 15'h7ffe);
	endproperty
	a_idx_down_miss: assert property (p_idx_down_miss) else $error("down skip miss");

	property p_char_ptr;
		go && opc == OP_CHAR_PTR && !dsg |=> s_ff.a == {7'h00, $past(chr)};
	endproperty
	a_char_ptr: assert property (p_char_ptr) else $error("char pointer load wrong");

	property p_null_op;
		go && !reg_wr && !dsg && ixf == 2'd0 && opc[5:2] == 4'h3
			|=> $stable(s_ff.a) && $stable(s_ff.q) && $stable(s_ff.bx);
	endproperty
	a_null_op: assert property (p_null_op) else $error("null op changed regs");

	property p_eq_skip;
		go && opc == OP_EQ_SKIP && sel_main && oc_norm(s_ff.a) == oc_norm(opnd)
			|=> exec_skip && exec_next_pc == 15'($past(exec_pc) + 15'd2);
	endproperty
	a_eq_skip: assert property (p_eq_skip) else $error("equal skip missed");

	property p_ge_noskip;
		go && opc == OP_GE_SKIP && !oc_ge(reg_val, opnd)
			|=> !exec_skip && exec_next_pc == 15'($past(exec_pc) + 15'd1);
	endproperty
	a_ge_noskip: assert property (p_ge_noskip) else $error("threshold skip wrong");

	property p_rot24;
		go && opc == OP_SHIFT_ONE && !dsg && !shift_right && shift_n == 6'd24
			|=> $stable(s_ff.a);
	endproperty
	a_rot24: assert property (p_rot24) else $error("rotate by 24 changed main");

	property p_right_fill;
		go && opc == OP_SHIFT_ONE && !dsg && shift_right && shift_n >= 6'd23
			|=> s_ff.a == {24{$past(s_ff.a[23])}};
	endproperty
	a_right_fill: assert property (p_right_fill) else $error("right fill wrong");

	property p_scale_stop;
		s_ff.busy && s_ff.a[23] != s_ff.a[22] |=> exec_done && !exec_busy;
	endproperty
	a_scale_stop: assert property (p_scale_stop) else $error("scale did not stop");

	// Positive and negative zero pairs both run the full count
	sequence s_zero_scale;
		go && opc == OP_SHIFT_DBL && dsg
			&& ({s_ff.a, s_ff.q} == 48'h000000000000 || {s_ff.a, s_ff.q} == 48'hffffffffffff);
	endsequence
	sequence s_scale_end;
		exec_done && !exec_busy && s_ff.cnt == 6'd48;
	endsequence
	property p_zero_scale;
		s_zero_scale |-> ##1 exec_busy [*8] ##42 s_scale_end;
	endproperty
	a_zero_scale: assert property (p_zero_scale) else $error("zero scale count wrong");

endmodule

/* File: verif/rie_seq_model.sv */
`timescale 1ns/100ps
// ******************************
// Sequencer model
// ******************************
module rie_seq_model (
	input wire logic core_clk,
	output logic exec_start,
	output logic [rie_pkg::WORD_W-1:0] exec_instr,
	output logic [rie_pkg::IDX_W-1:0] exec_pc,
	input wire logic exec_done,
	input wire logic [rie_pkg::IDX_W-1:0] exec_next_pc
);
	import rie_pkg::*;

	initial begin
		exec_start = 1'b0;
		exec_instr = 24'h000000;
		exec_pc = 15'h0000;
	end

	// Optional gap models a slow fetch; word and address go stale after start
	task automatic run(input logic [23:0] w, input logic [14:0] p, input int gap,
		output logic [14:0] np, output int n);
		repeat (gap) @(posedge core_clk);
		@(posedge core_clk);
		exec_start <= 1'b1;
		exec_instr <= w;
		exec_pc <= p;
		@(posedge core_clk);
		exec_start <= 1'b0;
		exec_instr <= ~w;
		exec_pc <= ~p;
		n = 1;
		#1;
		// Bounded wait, caller treats 60 as a hang
		while (exec_done !== 1'b1 && n < 60) begin
			@(posedge core_clk);
			#1;
			n++;
		end
		np = exec_next_pc;
	endtask
endmodule

/* File: verif/register_immediate_exec_unit_test.sv */
`timescale 1ns/100ps
// ******************************
// Test bench
// ******************************
module register_immediate_exec_unit_test;
	import rie_pkg::*;
	localparam logic [14:0] PC = 15'h0100;
	localparam logic [14:0] P1 = 15'h0101;
	localparam logic [14:0] P2 = 15'h0102;
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [23:0] reg_wdata = 24'h000000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [23:0] reg_rdata;
	logic exec_start;
	logic [23:0] exec_instr;
	logic [14:0] exec_pc;
	logic exec_done;
	logic [14:0] exec_next_pc;
	logic exec_skip;
	logic exec_busy;
	logic exec_bad_op;
	int n_fail = 0;
	int n_tests = 0;
	int last_n = 0;
	int busy_n = 0;

	always #25 core_clk = ~core_clk;

	always @(posedge core_clk) begin
		if (exec_busy === 1'b1) begin
			busy_n++;
		end
	end

	rie_exec u_dut (
		.core_clk(core_clk),
		.rstn(rstn),
		.exec_start(exec_start),
		.exec_instr(exec_instr),
		.exec_pc(exec_pc),
		.exec_done(exec_done),
		.exec_next_pc(exec_next_pc),
		.exec_skip(exec_skip),
		.exec_busy(exec_busy),
		.exec_bad_op(exec_bad_op),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_wr(reg_wr),
		.reg_rd(reg_rd),
		.reg_rdata(reg_rdata)
	);

	rie_seq_model u_seq (
		.core_clk(core_clk),
		.exec_start(exec_start),
		.exec_instr(exec_instr),
		.exec_pc(exec_pc),
		.exec_done(exec_done),
		.exec_next_pc(exec_next_pc)
	);

	// ******************************
	// Shared tasks
	// ******************************
	task automatic give_verdict();
		if (n_fail == 0 && n_tests > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [23:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [23:0] exp);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask

	function automatic logic [23:0] iw(logic [5:0] op, logic d, logic [1:0] b, logic [14:0] y);
		return {op, d, b, y};
	endfunction

	// Skip flag must agree with the continuation address every time
	task automatic ex(input logic [23:0] w, input logic [14:0] exp);
		logic [14:0] np;
		u_seq.run(w, PC, 0, np, last_n);
		if (last_n >= 60) begin
			n_fail++;
			give_verdict();
		end
		chk({9'h000, np}, {9'h000, exp});
		chk({23'h000000, exec_skip}, {23'h000000, exp == P2});
	endtask

	// ******************************
	// Scenarios
	// ******************************
	task automatic t_reset();
		wr(OFS_STATUS, 24'hffffff);
		for (int i = 0; i < 7; i++) begin
			rd(8'(i * 4), 24'h000000);
		end
	endtask

	task automatic t_alu();
		ex(iw(OP_ENTER, 1, 2, 15'h4001), P1);
		rd(OFS_MAIN, 24'h004001);
		ex(iw(OP_ENTER, 1, 0, 15'h4001), P1);
		rd(OFS_MAIN, 24'hffc001);
		wr(OFS_MAIN, 24'hfffffe);
		ex(iw(OP_ADD, 1, 2, 15'h0002), P1);
		rd(OFS_MAIN, 24'h000001);
		ex(iw(OP_ENTER, 1, 3, 15'h00ff), P1);
		ex(iw(OP_XOR, 1, 3, 15'h0f0f), P1);
		rd(OFS_AUX, 24'h000ff0);
		ex(iw(OP_AND, 1, 1, 15'h70f0), P1);
		rd(OFS_AUX, 24'h0000f0);
		ex(iw(OP_ENTER, 0, 1, 15'h0005), P1);
		ex(iw(OP_ADD, 0, 1, 15'h0003), P1);
		ex(iw(OP_XOR, 0, 1, 15'h000c), P1);
		ex(iw(OP_AND, 0, 1, 15'h0006), P1);
		rd(OFS_IDX1, 24'h000004);
		ex(iw(OP_ENTER, 0, 0, 15'h0007), P1);
		ex(iw(OP_ADD, 0, 0, 15'h0007), P1);
		rd(OFS_MAIN, 24'h000001);
	endtask

	task automatic t_skip();
		wr(OFS_MAIN, 24'h000010);
		wr(OFS_AUX, 24'hfffffe);
		ex(iw(OP_EQ_SKIP, 1, 2, 15'h0010), P2);
		ex(iw(OP_EQ_SKIP, 1, 2, 15'h0011), P1);
		ex(iw(OP_GE_SKIP, 1, 2, 15'h000f), P2);
		ex(iw(OP_GE_SKIP, 1, 2, 15'h0011), P1);
		ex(iw(OP_GE_SKIP, 1, 0, 15'h7fff), P2);
		ex(iw(OP_GE_SKIP, 1, 1, 15'h0000), P1);
		ex(iw(OP_EQ_SKIP, 0, 0, 15'h0000), P2);
		ex(iw(OP_EQ_SKIP, 0, 0, 15'h0001), P1);
		ex(iw(OP_GE_SKIP, 0, 0, 15'h0001), P1);
		ex(iw(OP_GE_SKIP, 0, 1, 15'h0004), P2);
		ex(iw(OP_GE_SKIP, 0, 1, 15'h0005), P1);
	endtask

	task automatic t_idx();
		ex(iw(OP_ENTER, 0, 2, 15'h7ffd), P1);
		ex(iw(OP_IDX_SKIP, 0, 2, 15'h0000), P1);
		rd(OFS_IDX2, 24'h007ffe);
		ex(iw(OP_IDX_SKIP, 0, 2, 15'h0000), P1);
		rd(OFS_IDX2, 24'h000000);
		ex(iw(OP_IDX_SKIP, 0, 2, 15'h0000), P2);
		rd(OFS_IDX2, 24'h000000);
		ex(iw(OP_IDX_SKIP, 1, 2, 15'h0005), P1);
		rd(OFS_IDX2, 24'h007ffe);
		ex(iw(OP_IDX_SKIP, 1, 2, 15'h7ffe), P2);
		rd(OFS_IDX2, 24'h000000);
	endtask

	task automatic t_char();
		ex({OP_CHAR_PTR, 1'b0, 17'h1abcd}, P1);
		rd(OFS_MAIN, 24'h01abcd);
		ex({OP_CHAR_PTR, 1'b1, 17'h1abcd}, P1);
		rd(OFS_MAIN, 24'hffabcd);
		ex({OP_CHAR_PTR, 1'b1, 17'h0abcd}, P1);
		rd(OFS_MAIN, 24'h00abcd);
	endtask

	task automatic t_shift();
		wr(OFS_MAIN, 24'h800001);
		ex(iw(OP_SHIFT_ONE, 0, 0, 15'h0001), P1);
		rd(OFS_MAIN, 24'h000003);
		ex(iw(OP_SHIFT_ONE, 0, 0, 15'h0018), P1);
		rd(OFS_MAIN, 24'h000003);
		ex(iw(OP_SHIFT_ONE, 0, 1, 15'h0015), P1);
		rd(OFS_MAIN, 24'h000006);
		ex(iw(OP_SHIFT_ONE, 0, 0, 15'h0040), P1);
		rd(OFS_MAIN, 24'h000006);
		wr(OFS_MAIN, 24'h800000);
		ex(iw(OP_SHIFT_ONE, 0, 0, 15'h7ff9), P1);
		rd(OFS_MAIN, 24'hfe0000);
		ex(iw(OP_SHIFT_ONE, 0, 0, 15'h7fe8), P1);
		rd(OFS_MAIN, 24'hffffff);
		wr(OFS_AUX, 24'h400000);
		ex(iw(OP_SHIFT_ONE, 1, 0, 15'h7fe8), P1);
		rd(OFS_AUX, 24'h000000);
	endtask

	task automatic t_dbl();
		wr(OFS_MAIN, 24'h800000);
		wr(OFS_AUX, 24'h000001);
		ex(iw(OP_SHIFT_DBL, 0, 0, 15'h0001), P1);
		rd(OFS_MAIN, 24'h000000);
		rd(OFS_AUX, 24'h000003);
		ex(iw(OP_SHIFT_DBL, 0, 0, 15'h0030), P1);
		rd(OFS_AUX, 24'h000003);
		wr(OFS_MAIN, 24'h800000);
		ex(iw(OP_SHIFT_DBL, 0, 0, 15'h7fd0), P1);
		rd(OFS_MAIN, 24'hffffff);
		rd(OFS_AUX, 24'hffffff);
	endtask

	task automatic t_scale();
		wr(OFS_MAIN, 24'h000001);
		wr(OFS_AUX, 24'h000000);
		// Bit 24 climbs to bit 46 in 22 shifts; done comes count plus two cycles on
		ex(iw(OP_SHIFT_DBL, 1, 1, 15'h001e), P1);
		chk(24'(last_n), 24'h000018);
		rd(OFS_MAIN, 24'h400000);
		rd(OFS_IDX1, 24'h000008);
		rd(OFS_STATUS, 24'h001600);
		wr(OFS_MAIN, 24'hffffff);
		wr(OFS_AUX, 24'hffffff);
		busy_n = 0;
		ex(iw(OP_SHIFT_DBL, 1, 0, 15'h0005), P1);
		chk(24'(last_n), 24'h000032);
		chk(24'(busy_n), 24'h000031);
		rd(OFS_IDX1, 24'h000008);
		rd(OFS_STATUS, 24'h003000);
	endtask

	// Unknown opcode must leave the main register alone
	task automatic t_bad();
		ex(iw(6'h00, 1, 2, 15'h0003), P1);
		chk({23'h000000, exec_bad_op}, 24'h000001);
		rd(OFS_MAIN, 24'hffffff);
		ex(iw(OP_ENTER, 0, 0, 15'h0000), P1);
		chk({23'h000000, exec_bad_op}, 24'h000000);
	endtask

	initial begin
		repeat (12) @(posedge core_clk);
		rstn <= 1'b1;
		t_reset();
		t_alu();
		t_skip();
		t_idx();
		t_char();
		t_shift();
		t_dbl();
		t_scale();
		t_bad();
		give_verdict();
	end
endmodule
